// ---- test/vlt_top_tb_top.sv ----
// self-checking bench of the video line trigger
// assumes a short vertical sync parameter and the source model
`timescale 1ns/10ps
`default_nettype none

module vlt_top_tb_top;
	logic clk, rst, wr_en, rd_en, trig_out, trig_prev;
	logic [3:0] chan_in;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	int fails, check_count, trig_cnt;

	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end

	vlt_top #(.VSYNC_CYC(8)) uut (.clk(clk), .rst(rst), .chan_in(chan_in), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .trig_out(trig_out));
	vlt_video_src src (.clk(clk), .chan_in(chan_in));

	// ------------------------------------------------------------
	// checks and bus tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %0h seen %0h", nm, exp, got);
		end
	endtask

	// a trigger wider than one cycle is a fault
	always @(posedge clk) begin
		if (trig_out === 1'b1) trig_cnt++;
		if (trig_out === 1'b1 && trig_prev === 1'b1) begin
			fails++;
			$display("wrong value trig_out width expected 1 seen 2");
		end
		trig_prev <= trig_out;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1;
		@(posedge clk);
		wr_en <= 0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd_en <= 1;
		@(posedge clk);
		rd_en <= 0;
		#1 chk($sformatf("reg %0h", a), exp, rdata);
		@(posedge clk);
		#1 chk("rdata after read cycle", 32'h00000000, rdata);
	endtask

	task automatic trig_chk(input int n);
		chk("trigger count", 32'(n), 32'(trig_cnt));
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic regs_reset();
		rd_chk(8'h00, 32'h00000040);
		rd_chk(8'h04, 32'h00000001);
		rd_chk(8'h08, 32'h00000001);
		rd_chk(8'h0C, 32'h00000014);
		rd_chk(8'h10, 32'h00000001);
		rd_chk(8'h18, 32'h00000000);
	endtask

	task automatic modes_limits();
		for (int m = 0; m < 6; m++) begin
			wr(8'h00, 32'(m << 2) | 32'h40);
			rd_chk(8'h00, 32'(m << 2) | 32'h40);
		end
		wr(8'h00, 32'h58);
		rd_chk(8'h00, 32'h54);
		// undefined standard code keeps the old standard, mode still written
		wr(8'h00, 32'hE4);
		rd_chk(8'h00, 32'h44);
		for (int s = 0; s < 5; s++) begin
			wr(8'h00, 32'(s << 5));
			rd_chk(8'h00, 32'(s << 5));
		end
		wr(8'h00, 32'h443);
		rd_chk(8'h00, 32'h443);
		wr(8'h00, 32'h4C);
		wr(8'h04, 32'h107);
		rd_chk(8'h04, 32'h107);
		wr(8'h04, 32'h108);
		rd_chk(8'h04, 32'h107);
		wr(8'h08, 32'h0);
		rd_chk(8'h08, 32'h1);
		wr(8'h08, 32'hF42400);
		rd_chk(8'h08, 32'hF42400);
		wr(8'h10, 32'h0);
		rd_chk(8'h10, 32'h1);
	endtask

	task automatic every_line();
		int n;
		wr(8'h00, 32'h146);
		src.idle(1'b1);
		wr(8'h0C, 32'h2);
		n = trig_cnt;
		src.pulse(2, 1);
		trig_chk(n);
		src.pulse(2, 2);
		trig_chk(n + 1);
		src.pulse(1, 3);
		trig_chk(n + 1);
		src.pulse(2, 5);
		trig_chk(n + 2);
	endtask

	task automatic line_count();
		int n;
		wr(8'h00, 32'h14D);
		wr(8'h04, 32'h3);
		n = trig_cnt;
		src.pulse(1, 8);
		trig_chk(n);
		// field one seen, waiting for the line, count restarted
		rd_chk(8'h14, 32'h00000003);
		repeat (2) src.pulse(1, 2);
		trig_chk(n);
		src.pulse(1, 2);
		trig_chk(n + 1);
		rd_chk(8'h14, 32'h00030001);
		src.pulse(1, 2);
		trig_chk(n + 1);
	endtask

	task automatic custom(input logic en);
		int n;
		wr(8'h00, 32'h383 | (32'(en) << 10));
		wr(8'h10, 32'h3);
		wr(8'h08, 32'h2);
		n = trig_cnt;
		src.pulse(3, 3);
		src.pulse(3, 2);
		trig_chk(n);
		src.pulse(3, 4);
		src.pulse(3, 2);
		trig_chk(n);
		src.pulse(3, 2);
		trig_chk(en ? n : n + 1);
		if (en) src.pulse(3, 2);
		trig_chk(n + 1);
		src.pulse(3, 2);
		trig_chk(n + 1);
	endtask

	task automatic finish_test();
		$display("fails %0d check_count %0d", fails, check_count);
		if (fails == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		rst = 1;
		wr_en = 0;
		rd_en = 0;
		addr = 8'h00;
		wdata = 32'h0;
		trig_prev = 0;
		fails = 0;
		check_count = 0;
		trig_cnt = 0;
		repeat (16) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		regs_reset();
		modes_limits();
		every_line();
		line_count();
		custom(1'b0);
		custom(1'b1);
		finish_test();
	end

	// bound on the whole run
	initial begin
		#2000000;
		fails++;
		$display("wrong value run state expected done seen timeout");
		finish_test();
	end
endmodule // vlt_top_tb_top

`default_nettype wire

// ---- test/vlt_video_src.sv ----
// video source model: sync pulses on one of four channel lines
// assumes tasks are called just after a rising clock edge
`timescale 1ns/10ps
`default_nettype none

module vlt_video_src (
	input wire logic clk,
	output logic [3:0] chan_in
);
	logic pos_q = 1'b0;

	initial chan_in = 4'hF;

	// idle lines sit at the inactive level so no stray run is seen
	task automatic idle(input logic pos);
		@(posedge clk);
		pos_q = pos;
		chan_in <= {4{~pos}};
	endtask

	// w active samples, then a gap long enough for any trigger
	task automatic pulse(input int ch, input int w);
		@(posedge clk);
		chan_in[ch] <= pos_q;
		repeat (w) @(posedge clk);
		chan_in[ch] <= ~pos_q;
		repeat (6) @(posedge clk);
	endtask
endmodule // vlt_video_src

`default_nettype wire

// ---- verilog/vlt_pkg.sv ----
// constants, field layout and enumerations of the video line trigger
// assumes a 10 MHz sample clock; used by the top only, its two leaves do not import it
package vlt_pkg;

	// ------------------------------------------------------------
	// clock and times
	// ------------------------------------------------------------
	localparam int CLK_NS = 100;
	localparam int PGTH_MIN_NS = 5;
	localparam longint PGTH_MAX_NS = 64'd9999999900;
	localparam int VSYNC_MIN_NS = 20000;
	localparam int HSYNC_DEF_NS = 2000;
	localparam int PGTH_MIN_RAW = (PGTH_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned PGTH_MIN_CYC = (PGTH_MIN_RAW < 1) ? 1 : PGTH_MIN_RAW;
	localparam int unsigned PGTH_MAX_CYC = 32'(PGTH_MAX_NS / CLK_NS);
	localparam int unsigned VSYNC_CYC = (VSYNC_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned HSYNC_DEF_CYC = (HSYNC_DEF_NS + CLK_NS - 1) / CLK_NS;

	// ------------------------------------------------------------
	// widths and register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int N_CH = 4;
	localparam int SRC_W = 2;
	localparam int MODE_W = 3;
	localparam int STD_W = 3;
	localparam int LINE_W = 11;
	localparam int EV_W = 24;
	localparam int PW_W = 27;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_LINE = 8'h04;
	localparam logic [7:0] OFF_EVCNT = 8'h08;
	localparam logic [7:0] OFF_SYNC_WIDTH_QUALIFIER = 8'h0C;
	localparam logic [7:0] OFF_PGTH = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam int CTRL_SRC_LSB = 0;
	localparam int CTRL_MODE_LSB = 2;
	localparam int CTRL_STD_LSB = 5;
	localparam int CTRL_TVPOL_BIT = 8;
	localparam int CTRL_UDPOL_BIT = 9;
	localparam int CTRL_HSYNC_BIT = 10;
	localparam int ST_FIELD_BIT = 0;
	localparam int ST_WAIT_BIT = 1;
	localparam int ST_CST_LSB = 2;
	localparam int ST_LINE_LSB = 16;

	// ------------------------------------------------------------
	// line limits and reset values
	// ------------------------------------------------------------
	localparam logic [10:0] LINE_MIN = 11'h001;
	localparam logic [10:0] LINES_525_FORMAT_F1_MAX = 11'h107;
	localparam logic [10:0] LINES_525_FORMAT_F2_MAX = 11'h106;
	localparam logic [10:0] LINES_525_FORMAT_FRAME = 11'h20D;
	localparam logic [10:0] LINES_625_FORMAT_F1_MAX = 11'h139;
	localparam logic [10:0] LINES_625_FORMAT_F2_MIN = 11'h13A;
	localparam logic [10:0] LINES_625_FORMAT_ALT_MAX = 11'h138;
	localparam logic [10:0] LINES_625_FORMAT_FRAME = 11'h271;
	localparam logic [10:0] L1080_FRAME = 11'h465;
	localparam int unsigned EV_MIN = 32'h00000001;
	localparam int unsigned EV_MAX = 32'h00F42400;
	localparam logic [10:0] RST_LINE = 11'h001;
	localparam logic [23:0] RST_EVCNT = 24'h000001;
	localparam logic [26:0] RST_SYNC_WIDTH_QUALIFIER = 27'(HSYNC_DEF_CYC);
	localparam logic [26:0] RST_PGTH = 27'(PGTH_MIN_CYC);

	// ------------------------------------------------------------
	// enumerations
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		every_field_mode,
		every_line_mode,
		alternate_field_mode,
		first_field_mode,
		second_field_mode,
		line_mode
	} vlt_mode_t;

	typedef enum logic [2:0] {
		interlaced_1080_at_60hz,
		interlaced_1080_at_50hz,
		lines_525_format,
		lines_625_format,
		custom_video_format
	} vlt_std_t;

	typedef enum logic [1:0] {
		cst_idle,
		cst_count,
		cst_search
	} vlt_cst_t;

endpackage

// ---- verilog/vlt_pulse_qual.sv ----
// pulse width qualifier: one pulse per run of the active level once it lasts thr cycles
// assumes thr is never zero; run counter saturates so long pulses fire once
`timescale 1ns/10ps
`default_nettype none

module vlt_pulse_qual #(
	parameter int W = 27
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic act,
	input wire logic [W-1:0] thr,
	output logic qual_q
);
	logic [W-1:0] run_q;

	always_ff @(posedge clk) begin
		if (rst || !act) begin
			run_q <= {W{1'b0}};
		end else if (run_q != {W{1'b1}}) begin
			run_q <= run_q + W'(1);
		end
	end

	// shorter runs never reach thr and are dropped
	always_ff @(posedge clk) begin
		if (rst) begin
			qual_q <= 1'b0;
		end else begin
			qual_q <= act && (run_q + W'(1) == thr);
		end
	end

	a_qual_width:
	assert property (@(posedge clk) disable iff (rst) qual_q |-> run_q == thr && $past(act))
		else $error("qualified pulse without full width");

	a_qual_single:
	assert property (@(posedge clk) disable iff (rst) qual_q |=> !qual_q)
		else $error("qualifier fired twice in a row");

endmodule // vlt_pulse_qual

`default_nettype wire

// ---- verilog/vlt_src_sel.sv ----
// channel picker with polarity: flags the sync-active level of one channel
// assumes channel inputs are digitised comparator levels, synchronous to clk
`timescale 1ns/10ps
`default_nettype none

module vlt_src_sel #(
	parameter int N_CH = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [N_CH-1:0] chan_in,
	input wire logic [$clog2(N_CH)-1:0] sel,
	input wire logic pol,
	output logic act_q
);
	localparam int SEL_W = $clog2(N_CH);

	logic [N_CH-1:0] hit;

	// negative polarity means the pulse is the low level
	genvar g;
	generate
		for (g = 0; g < N_CH; g++) begin : g_ch
			assign hit[g] = (sel == SEL_W'(g)) && (chan_in[g] ~^ pol);
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (rst) begin
			act_q <= 1'b0;
		end else begin
			act_q <= |hit;
		end
	end

endmodule // vlt_src_sel

`default_nettype wire

// ---- verilog/vlt_top.sv ----
// video line trigger: sync detection, field and line counting, custom-format arming
// assumes one 10 MHz clock, synchronous digitised channels, plain register port
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - after the chosen field's vertical sync, count lines and trigger at the target
// - line writes outside the range for standard and mode are ignored
// - mode picks every field, every line, alternate, first, second or one line
// - vertical sync of the programmed polarity is detected and toggles the field
// - one of four channels feeds every sync detector
// - standard picks a 1080 interlaced, 525, 625 or custom format
// - custom format: after arming count 1 to 16,000,000 horizontal syncs
// - one bit enables horizontal-sync triggering in custom format, read back as written
// - horizontal sync pulses shorter than the programmed width are ignored
// - arming needs a pulse wider than the programmed minimum, 5 ns to 9.9999999 s; the code's lowest setting is one 100 ns cycle
// - arming pulse uses its own polarity setting
// - every setting reads back as the value in effect
module vlt_top #(
	parameter int unsigned PGTH_MAX_CYC = vlt_pkg::PGTH_MAX_CYC,
	parameter int unsigned EV_MAX = vlt_pkg::EV_MAX,
	parameter int unsigned VSYNC_CYC = vlt_pkg::VSYNC_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [vlt_pkg::N_CH-1:0] chan_in,
	input wire logic [vlt_pkg::ADDR_W-1:0] addr,
	input wire logic [vlt_pkg::DATA_W-1:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [vlt_pkg::DATA_W-1:0] rdata,
	output logic trig_out
);
	// ------------------------------------------------------------
	// settings
	// ------------------------------------------------------------
	logic [vlt_pkg::SRC_W-1:0] src_q;
	vlt_pkg::vlt_mode_t mode_q;
	vlt_pkg::vlt_std_t std_q;
	logic tv_pol_q;
	logic ud_pol_q;
	logic hs_en_q;
	logic [vlt_pkg::LINE_W-1:0] line_q;
	logic [vlt_pkg::EV_W-1:0] evcnt_q;
	logic [vlt_pkg::PW_W-1:0] sync_width_qualifier_q;
	logic [vlt_pkg::PW_W-1:0] pgth_q;
	logic [vlt_pkg::DATA_W-1:0] rdata_q;
	logic [vlt_pkg::DATA_W-1:0] rd_d;

	logic wr_ctrl;
	logic wr_line;
	logic wr_evcnt;
	logic wr_sync_width_qualifier;
	logic wr_pgth;
	logic line_wr_ok;
	logic mode_wr_ok;
	logic std_wr_ok;

	assign wr_ctrl = wr_en && (addr == vlt_pkg::OFF_CTRL);
	assign wr_line = wr_en && (addr == vlt_pkg::OFF_LINE);
	assign wr_evcnt = wr_en && (addr == vlt_pkg::OFF_EVCNT);
	assign wr_sync_width_qualifier = wr_en && (addr == vlt_pkg::OFF_SYNC_WIDTH_QUALIFIER);
	assign wr_pgth = wr_en && (addr == vlt_pkg::OFF_PGTH);
	assign mode_wr_ok = wdata[vlt_pkg::CTRL_MODE_LSB +: vlt_pkg::MODE_W] <= vlt_pkg::line_mode;
	assign std_wr_ok = wdata[vlt_pkg::CTRL_STD_LSB +: vlt_pkg::STD_W]
		<= vlt_pkg::custom_video_format;

	// legal line window depends on the standard and mode in effect
	function automatic logic line_ok(
		input vlt_pkg::vlt_std_t s,
		input vlt_pkg::vlt_mode_t m,
		input logic [vlt_pkg::DATA_W-1:0] n
	);
		logic [vlt_pkg::LINE_W-1:0] lo;
		logic [vlt_pkg::LINE_W-1:0] hi;
		lo = vlt_pkg::LINE_MIN;
		hi = vlt_pkg::L1080_FRAME;
		case (s)
			vlt_pkg::lines_525_format: begin
				if (m == vlt_pkg::first_field_mode) begin
					hi = vlt_pkg::LINES_525_FORMAT_F1_MAX;
				end else if (m == vlt_pkg::line_mode) begin
					hi = vlt_pkg::LINES_525_FORMAT_FRAME;
				end else begin
					hi = vlt_pkg::LINES_525_FORMAT_F2_MAX;
				end
			end
			vlt_pkg::lines_625_format: begin
				if (m == vlt_pkg::first_field_mode) begin
					hi = vlt_pkg::LINES_625_FORMAT_F1_MAX;
				end else if (m == vlt_pkg::second_field_mode) begin
					lo = vlt_pkg::LINES_625_FORMAT_F2_MIN;
					hi = vlt_pkg::LINES_625_FORMAT_FRAME;
				end else if (m == vlt_pkg::line_mode) begin
					hi = vlt_pkg::LINES_625_FORMAT_FRAME;
				end else begin
					hi = vlt_pkg::LINES_625_FORMAT_ALT_MAX;
				end
			end
			default: begin
				hi = vlt_pkg::L1080_FRAME;
			end
		endcase
		return (n >= 32'(lo)) && (n <= 32'(hi));
	endfunction

	assign line_wr_ok = line_ok(std_q, mode_q, wdata);

	// out-of-range writes leave the old value in effect
	always_ff @(posedge clk) begin
		if (rst) begin
			src_q <= 2'h0;
			mode_q <= vlt_pkg::every_field_mode;
			std_q <= vlt_pkg::lines_525_format;
			tv_pol_q <= 1'b0;
			ud_pol_q <= 1'b0;
			hs_en_q <= 1'b0;
		end else if (wr_ctrl) begin
			src_q <= wdata[vlt_pkg::CTRL_SRC_LSB +: vlt_pkg::SRC_W];
			if (mode_wr_ok) begin
				mode_q <= vlt_pkg::vlt_mode_t'(wdata[vlt_pkg::CTRL_MODE_LSB +: vlt_pkg::MODE_W]);
			end
			if (std_wr_ok) begin
				std_q <= vlt_pkg::vlt_std_t'(wdata[vlt_pkg::CTRL_STD_LSB +: vlt_pkg::STD_W]);
			end
			tv_pol_q <= wdata[vlt_pkg::CTRL_TVPOL_BIT];
			ud_pol_q <= wdata[vlt_pkg::CTRL_UDPOL_BIT];
			hs_en_q <= wdata[vlt_pkg::CTRL_HSYNC_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			line_q <= vlt_pkg::RST_LINE;
			evcnt_q <= vlt_pkg::RST_EVCNT;
			sync_width_qualifier_q <= vlt_pkg::RST_SYNC_WIDTH_QUALIFIER;
			pgth_q <= vlt_pkg::RST_PGTH;
		end else begin
			if (wr_line && line_wr_ok) begin
				line_q <= wdata[vlt_pkg::LINE_W-1:0];
			end
			if (wr_evcnt && wdata >= vlt_pkg::EV_MIN && wdata <= EV_MAX) begin
				evcnt_q <= wdata[vlt_pkg::EV_W-1:0];
			end
			if (wr_sync_width_qualifier && wdata >= 32'h00000001 && wdata <= PGTH_MAX_CYC) begin
				sync_width_qualifier_q <= wdata[vlt_pkg::PW_W-1:0];
			end
			if (wr_pgth && wdata >= vlt_pkg::PGTH_MIN_CYC && wdata <= PGTH_MAX_CYC) begin
				pgth_q <= wdata[vlt_pkg::PW_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// sync detection
	// ------------------------------------------------------------
	logic act_tv;
	logic act_ud;
	logic hs_ev;
	logic vs_ev;
	logic arm_ev;
	logic [vlt_pkg::PW_W-1:0] arm_thr;

	// strictly wider than the minimum: one cycle past it
	assign arm_thr = pgth_q + 27'h0000001;

	vlt_src_sel #(.N_CH(vlt_pkg::N_CH)) u_sel_tv (
		.clk(clk),
		.rst(rst),
		.chan_in(chan_in),
		.sel(src_q),
		.pol(tv_pol_q),
		.act_q(act_tv)
	);

	vlt_src_sel #(.N_CH(vlt_pkg::N_CH)) u_sel_ud (
		.clk(clk),
		.rst(rst),
		.chan_in(chan_in),
		.sel(src_q),
		.pol(ud_pol_q),
		.act_q(act_ud)
	);

	vlt_pulse_qual #(.W(vlt_pkg::PW_W)) u_hs_qual (
		.clk(clk),
		.rst(rst),
		.act(act_tv),
		.thr(sync_width_qualifier_q),
		.qual_q(hs_ev)
	);

	// a vertical pulse also counts as a line once; it then restarts the count
	vlt_pulse_qual #(.W(vlt_pkg::PW_W)) u_vs_qual (
		.clk(clk),
		.rst(rst),
		.act(act_tv),
		.thr(vlt_pkg::PW_W'(VSYNC_CYC)),
		.qual_q(vs_ev)
	);

	vlt_pulse_qual #(.W(vlt_pkg::PW_W)) u_arm_qual (
		.clk(clk),
		.rst(rst),
		.act(act_ud),
		.thr(arm_thr),
		.qual_q(arm_ev)
	);

	// ------------------------------------------------------------
	// field tracking and line counting
	// ------------------------------------------------------------
	logic is_custom;
	logic field_one_q;
	logic alt_q;
	logic wait_q;
	logic [vlt_pkg::LINE_W-1:0] line_cnt_q;
	logic [vlt_pkg::LINE_W-1:0] target_q;
	logic [vlt_pkg::LINE_W-1:0] target_d;
	logic field_qual;
	logic line_hit;
	logic std_trig;

	assign is_custom = (std_q == vlt_pkg::custom_video_format);
	assign line_hit = (line_cnt_q + 11'h001 == target_q);

	// no field-parity measure: fields simply alternate on every vertical sync
	always_ff @(posedge clk) begin
		if (rst) begin
			field_one_q <= 1'b0;
			alt_q <= 1'b1;
		end else if (vs_ev) begin
			field_one_q <= !field_one_q;
			alt_q <= !alt_q;
		end
	end

	always_comb begin
		case (mode_q)
			vlt_pkg::every_field_mode: field_qual = 1'b1;
			vlt_pkg::alternate_field_mode: field_qual = alt_q;
			vlt_pkg::first_field_mode: field_qual = !field_one_q;
			vlt_pkg::line_mode: field_qual = !field_one_q;
			vlt_pkg::second_field_mode: field_qual = field_one_q;
			default: field_qual = 1'b0;
		endcase
	end

	// second field of 625 counts from its own sync, numbers from the first
	always_comb begin
		target_d = line_q;
		if (std_q == vlt_pkg::lines_625_format && mode_q == vlt_pkg::second_field_mode) begin
			target_d = line_q - vlt_pkg::LINES_625_FORMAT_F1_MAX;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || wr_ctrl || is_custom) begin
			wait_q <= 1'b0;
			line_cnt_q <= 11'h000;
			target_q <= vlt_pkg::RST_LINE;
		end else if (vs_ev) begin
			if (field_qual) begin
				wait_q <= 1'b1;
				line_cnt_q <= 11'h000;
				target_q <= target_d;
			end else if (mode_q != vlt_pkg::line_mode) begin
				wait_q <= 1'b0;
			end
		end else if (hs_ev && wait_q) begin
			line_cnt_q <= line_cnt_q + 11'h001;
			if (line_hit) begin
				wait_q <= 1'b0;
			end
		end
	end

	assign std_trig = !is_custom && hs_ev && !vs_ev
		&& ((mode_q == vlt_pkg::every_line_mode) || (wait_q && line_hit));

	// ------------------------------------------------------------
	// custom format arming
	// ------------------------------------------------------------
	vlt_pkg::vlt_cst_t cst_q;
	logic [vlt_pkg::EV_W-1:0] ev_cnt_q;
	logic ev_hit;
	logic cust_trig;

	assign ev_hit = (ev_cnt_q + 24'h000001 == evcnt_q);

	always_ff @(posedge clk) begin
		if (rst || wr_ctrl || !is_custom) begin
			cst_q <= vlt_pkg::cst_idle;
			ev_cnt_q <= 24'h000000;
		end else begin
			case (cst_q)
				vlt_pkg::cst_idle: begin
					if (arm_ev) begin
						cst_q <= vlt_pkg::cst_count;
						ev_cnt_q <= 24'h000000;
					end
				end
				vlt_pkg::cst_count: begin
					if (hs_ev) begin
						ev_cnt_q <= ev_cnt_q + 24'h000001;
						if (ev_hit) begin
							cst_q <= hs_en_q ? vlt_pkg::cst_search : vlt_pkg::cst_idle;
						end
					end
				end
				vlt_pkg::cst_search: begin
					if (hs_ev) begin
						cst_q <= vlt_pkg::cst_idle;
					end
				end
				default: begin
					cst_q <= vlt_pkg::cst_idle;
				end
			endcase
		end
	end

	assign cust_trig = is_custom && hs_ev && ((cst_q == vlt_pkg::cst_count && ev_hit && !hs_en_q)
		|| (cst_q == vlt_pkg::cst_search));

	always_ff @(posedge clk) begin
		if (rst) begin
			trig_out <= 1'b0;
		end else begin
			trig_out <= std_trig || cust_trig;
		end
	end

	// ------------------------------------------------------------
	// readback
	// ------------------------------------------------------------
	always_comb begin
		rd_d = 32'h00000000;
		case (addr)
			vlt_pkg::OFF_CTRL: begin
				rd_d[vlt_pkg::CTRL_SRC_LSB +: vlt_pkg::SRC_W] = src_q;
				rd_d[vlt_pkg::CTRL_MODE_LSB +: vlt_pkg::MODE_W] = mode_q;
				rd_d[vlt_pkg::CTRL_STD_LSB +: vlt_pkg::STD_W] = std_q;
				rd_d[vlt_pkg::CTRL_TVPOL_BIT] = tv_pol_q;
				rd_d[vlt_pkg::CTRL_UDPOL_BIT] = ud_pol_q;
				rd_d[vlt_pkg::CTRL_HSYNC_BIT] = hs_en_q;
			end
			vlt_pkg::OFF_LINE: rd_d[vlt_pkg::LINE_W-1:0] = line_q;
			vlt_pkg::OFF_EVCNT: rd_d[vlt_pkg::EV_W-1:0] = evcnt_q;
			vlt_pkg::OFF_SYNC_WIDTH_QUALIFIER: rd_d[vlt_pkg::PW_W-1:0] = sync_width_qualifier_q;
			vlt_pkg::OFF_PGTH: rd_d[vlt_pkg::PW_W-1:0] = pgth_q;
			vlt_pkg::OFF_STATUS: begin
				rd_d[vlt_pkg::ST_FIELD_BIT] = field_one_q;
				rd_d[vlt_pkg::ST_WAIT_BIT] = wait_q;
				rd_d[vlt_pkg::ST_CST_LSB +: 2] = cst_q;
				rd_d[vlt_pkg::ST_LINE_LSB +: vlt_pkg::LINE_W] = line_cnt_q;
			end
			default: rd_d = 32'h00000000;
		endcase
	end

	// data only in the cycle after the read strobe, zero otherwise
	always_ff @(posedge clk) begin
		if (rst || !rd_en) begin
			rdata_q <= 32'h00000000;
		end else begin
			rdata_q <= rd_d;
		end
	end

	assign rdata = rdata_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic tv_raw;
	logic ud_raw;

	assign tv_raw = chan_in[src_q] ~^ tv_pol_q;
	assign ud_raw = chan_in[src_q] ~^ ud_pol_q;

	a_line_hit:
	assert property (@(posedge clk) disable iff (rst)
		!is_custom && wait_q && hs_ev && !vs_ev && line_hit |=> trig_out && !wait_q)
		else $error("target line reached without trigger");

	a_line_range:
	assert property (@(posedge clk) disable iff (rst)
		wr_line && !line_wr_ok |=> $stable(line_q))
		else $error("out-of-range line number accepted");

	a_every_line:
	assert property (@(posedge clk) disable iff (rst)
		!is_custom && mode_q == vlt_pkg::every_line_mode && hs_ev && !vs_ev |=> trig_out)
		else $error("every-line mode missed a line");

	a_vsync_field:
	assert property (@(posedge clk) disable iff (rst)
		vs_ev |=> field_one_q != $past(field_one_q))
		else $error("field did not advance on vertical sync");

	a_source_pick:
	assert property (@(posedge clk) disable iff (rst) ##1 act_tv == $past(tv_raw))
		else $error("sync detector not fed by selected channel");

	a_std_reject:
	assert property (@(posedge clk) disable iff (rst)
		wr_ctrl && !std_wr_ok |=> std_q == $past(std_q))
		else $error("undefined standard code accepted");

	a_event_count:
	assert property (@(posedge clk) disable iff (rst)
		is_custom && cst_q == vlt_pkg::cst_count && hs_ev && ev_hit && !hs_en_q |=> trig_out)
		else $error("event count reached without trigger");

	a_hsync_read:
	assert property (@(posedge clk) disable iff (rst)
		rd_en && addr == vlt_pkg::OFF_CTRL |=> rdata[vlt_pkg::CTRL_HSYNC_BIT] == $past(hs_en_q))
		else $error("horizontal sync enable read back wrong");

	a_pgth_reject:
	assert property (@(posedge clk) disable iff (rst)
		wr_pgth && (wdata < vlt_pkg::PGTH_MIN_CYC || wdata > PGTH_MAX_CYC) |=> $stable(pgth_q))
		else $error("arming width outside limits accepted");

	a_arm_polarity:
	assert property (@(posedge clk) disable iff (rst) ##1 act_ud == $past(ud_raw))
		else $error("arming pulse polarity not applied");

	a_line_read:
	assert property (@(posedge clk) disable iff (rst)
		rd_en && addr == vlt_pkg::OFF_LINE |=> rdata == {21'h000000, $past(line_q)})
		else $error("line number read back wrong");

	a_trig_single:
	assert property (@(posedge clk) disable iff (rst) trig_out |=> !trig_out)
		else $error("trigger longer than one cycle");

endmodule // vlt_top

`default_nettype wire
